/* hdl/ptc_top.v */
// Purpose: Position teach controller with AXI4-Lite register access.
// Assumes: Axis positions and origin bits come from logic on aclk.
// Notes: Position data words are read back through the memory window.
//
// The AXI4-Lite slave port and the register offsets were decided locally.
`timescale 1ns/100ps
`include "ptc_defs.vh"
module ptc_top (
    input wire aclk,
    input wire aresetn,
    input wire [15:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [15:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire [32*`PTC_NT*`PTC_NA-1:0] pos_target,
    input wire [32*`PTC_NT*`PTC_NA-1:0] pos_feedback,
    input wire [`PTC_NT*`PTC_NA-1:0] origin_ok,
    output reg irq
);

localparam ST_IDLE = 2'h0;
localparam ST_WR = 2'h1;
localparam ST_FIN = 2'h2;

reg [2*`PTC_NT-1:0] req_q;
reg [16*`PTC_NT-1:0] swd_q;
reg [16*`PTC_NT-1:0] wlo_q;
reg [16*`PTC_NT-1:0] whi_q;
reg src_fb_q;
reg [4*`PTC_NT-1:0] istat_q;
reg [4*`PTC_NT-1:0] imask_q;
reg [15:0] aw_q;
reg awf_q;
reg [31:0] wd_q;
reg [3:0] ws_q;
reg wf_q;
reg [31:0] mem [0:`PTC_DEPTH-1];

wire [4*`PTC_NT-1:0] flg;
wire [16*`PTC_NT-1:0] tad;
wire [4*`PTC_NT-1:0] ev;
wire [`PTC_NT-1:0] wr_req;
wire [16*`PTC_NT-1:0] wr_addr;
wire [32*`PTC_NT-1:0] wr_data;
// Lowest-numbered task wins the single memory write port.
wire [`PTC_NT-1:0] gnt = wr_req & (~wr_req + {{(`PTC_NT-1){1'b0}}, 1'b1});

genvar t;
generate
    for (t = 0; t < `PTC_NT; t = t + 1)
    begin : g_task
        reg [1:0] st_q;
        reg [15:0] ta_q;
        reg ax_q;
        reg [3:0] fl_q;
        reg [3:0] flp_q;
        reg [32*`PTC_NA-1:0] snap_q;
        wire sr = req_q[2*t+`PTC_RQ_SET];
        wire tr = req_q[2*t+`PTC_RQ_TCH];
        wire [15:0] lo = wlo_q[16*t+:16];
        wire [15:0] hi = whi_q[16*t+:16];
        wire no_org = ~&origin_ok[`PTC_NA*t+:`PTC_NA];
        wire bad_abs = ta_q > `PTC_ABS_MAX;
        wire [16:0] last = {1'b0, ta_q} + 17'h00001;
        wire over = (ta_q < lo) || (last > {1'b0, hi});
        always @(posedge aclk)
        begin
            if (!aresetn)
            begin
                st_q <= ST_IDLE;
                ta_q <= 16'h0000;
                ax_q <= 1'b0;
                fl_q <= 4'h0;
                flp_q <= 4'h0;
                snap_q <= {32*`PTC_NA{1'b0}};
            end
            else
            begin
                flp_q <= fl_q;
                case (st_q)
                    ST_IDLE:
                    begin
                        if (sr)
                        begin
                            ta_q <= swd_q[16*t+:16];
                            fl_q[`PTC_FL_SET] <= 1'b1;
                            st_q <= ST_FIN;
                        end
                        else if (tr)
                        begin
                            if (no_org || bad_abs)
                            begin
                                fl_q[`PTC_FL_ERR] <= 1'b1;
                                st_q <= ST_FIN;
                            end
                            else if (over)
                            begin
                                fl_q[`PTC_FL_OVR] <= 1'b1;
                                st_q <= ST_FIN;
                            end
                            else
                            begin
                                // Snapshot all axes at once so X and Y belong to one instant.
                                snap_q <= src_fb_q ? pos_feedback[32*`PTC_NA*t+:32*`PTC_NA] :
                                    pos_target[32*`PTC_NA*t+:32*`PTC_NA];
                                ax_q <= 1'b0;
                                st_q <= ST_WR;
                            end
                        end
                    end
                    ST_WR:
                    begin
                        if (gnt[t])
                        begin
                            ax_q <= ~ax_q;
                            if (ax_q)
                            begin
                                ta_q <= ta_q + `PTC_STEP;
                                fl_q[`PTC_FL_DONE] <= 1'b1;
                                st_q <= ST_FIN;
                            end
                        end
                    end
                    ST_FIN:
                    begin
                        if (!sr && !tr)
                        begin
                            fl_q <= 4'h0;
                            st_q <= ST_IDLE;
                        end
                    end
                    default: st_q <= ST_IDLE;
                endcase
            end
        end
        assign flg[4*t+:4] = fl_q;
        assign tad[16*t+:16] = ta_q;
        assign ev[4*t+:4] = fl_q & ~flp_q;
        assign wr_req[t] = (st_q == ST_WR);
        assign wr_addr[16*t+:16] = ta_q + {15'h0000, ax_q};
        assign wr_data[32*t+:32] = ax_q ? snap_q[63:32] : snap_q[31:0];
    end
endgenerate

reg [15:0] ma_d;
reg [31:0] md_d;
integer k;
always @*
begin
    ma_d = 16'h0000;
    md_d = 32'h00000000;
    for (k = 0; k < `PTC_NT; k = k + 1)
    begin
        if (gnt[k])
        begin
            ma_d = wr_addr[16*k+:16];
            md_d = wr_data[32*k+:32];
        end
    end
end

// Position memory has no reset; software must not trust unwritten words.
always @(posedge aclk)
begin
    if ((|gnt) && (ma_d < `PTC_DEPTH))
    begin
        mem[ma_d[10:0]] <= md_d;
    end
end

wire [31:0] bm = {{8{ws_q[3]}}, {8{ws_q[2]}}, {8{ws_q[1]}}, {8{ws_q[0]}}};
wire [31:0] wv = wd_q & bm;
wire do_wr = awf_q && wf_q && !s_axi_bvalid;
wire w_task = (aw_q & `PTC_TASK_MASK) == `PTC_TASK_AREA;
wire w_win = (aw_q & `PTC_WIN_MASK) == `PTC_WIN_BASE;
wire w_ti = w_task ? aw_q[4] : aw_q[3];
wire w_ok = w_task || w_win || (aw_q == `PTC_CFG) || (aw_q == `PTC_ISTAT) || (aw_q == `PTC_IMASK);

always @(posedge aclk)
begin
    if (!aresetn)
    begin
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= `PTC_RESP_OK;
        aw_q <= 16'h0000;
        awf_q <= 1'b0;
        wd_q <= 32'h00000000;
        ws_q <= 4'h0;
        wf_q <= 1'b0;
        req_q <= {2*`PTC_NT{1'b0}};
        swd_q <= {16*`PTC_NT{1'b0}};
        wlo_q <= {`PTC_NT{`PTC_WLO_RST}};
        whi_q <= {`PTC_NT{`PTC_WHI_RST}};
        src_fb_q <= 1'b0;
        imask_q <= {4*`PTC_NT{1'b0}};
    end
    else
    begin
        if (s_axi_awvalid && s_axi_awready)
        begin
            aw_q <= s_axi_awaddr;
            awf_q <= 1'b1;
            s_axi_awready <= 1'b0;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            wd_q <= s_axi_wdata;
            ws_q <= s_axi_wstrb;
            wf_q <= 1'b1;
            s_axi_wready <= 1'b0;
        end
        if (do_wr)
        begin
            awf_q <= 1'b0;
            wf_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= w_ok ? `PTC_RESP_OK : `PTC_RESP_ERR;
            if (w_task && aw_q[3:0] == `PTC_REQ && ws_q[0])
            begin
                req_q[2*w_ti+:2] <= wd_q[1:0];
            end
            if (w_task && aw_q[3:0] == `PTC_SWD)
            begin
                swd_q[16*w_ti+:16] <= (swd_q[16*w_ti+:16] & ~bm[15:0]) | wv[15:0];
            end
            if (w_win && !aw_q[2])
            begin
                wlo_q[16*w_ti+:16] <= (wlo_q[16*w_ti+:16] & ~bm[15:0]) | wv[15:0];
            end
            if (w_win && aw_q[2])
            begin
                whi_q[16*w_ti+:16] <= (whi_q[16*w_ti+:16] & ~bm[15:0]) | wv[15:0];
            end
            if (aw_q == `PTC_CFG && ws_q[0])
            begin
                src_fb_q <= wd_q[0];
            end
            if (aw_q == `PTC_IMASK && ws_q[0])
            begin
                imask_q <= wd_q[4*`PTC_NT-1:0];
            end
        end
        if (s_axi_bvalid && s_axi_bready)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
        end
    end
end

wire [15:0] ra = s_axi_araddr;
wire [15:0] moff = ra - `PTC_MEM_BASE;
wire [15:0] midx = {2'b00, moff[15:2]};
wire r_task = (ra & `PTC_TASK_MASK) == `PTC_TASK_AREA;
wire r_win = (ra & `PTC_WIN_MASK) == `PTC_WIN_BASE;
wire r_ti = r_task ? ra[4] : ra[3];
wire r_mem = (ra >= `PTC_MEM_BASE) && (midx < `PTC_DEPTH) && (ra[1:0] == 2'h0);
reg [31:0] rd_d;
reg rok_d;
always @*
begin
    rd_d = 32'h00000000;
    rok_d = 1'b1;
    if (r_task && ra[3:0] == `PTC_REQ)
    begin
        rd_d[1:0] = req_q[2*r_ti+:2];
    end
    else if (r_task && ra[3:0] == `PTC_FLG)
    begin
        rd_d[3:0] = flg[4*r_ti+:4];
    end
    else if (r_task && ra[3:0] == `PTC_SWD)
    begin
        rd_d[15:0] = swd_q[16*r_ti+:16];
    end
    else if (r_task && ra[3:0] == `PTC_TAD)
    begin
        rd_d[15:0] = tad[16*r_ti+:16];
    end
    else if (r_win)
    begin
        rd_d[15:0] = ra[2] ? whi_q[16*r_ti+:16] : wlo_q[16*r_ti+:16];
    end
    else if (ra == `PTC_CFG)
    begin
        rd_d[0] = src_fb_q;
    end
    else if (ra == `PTC_ISTAT)
    begin
        rd_d[4*`PTC_NT-1:0] = istat_q;
    end
    else if (ra == `PTC_IMASK)
    begin
        rd_d[4*`PTC_NT-1:0] = imask_q;
    end
    else if (r_mem)
    begin
        rd_d = mem[midx[10:0]];
    end
    else
    begin
        rok_d = 1'b0;
    end
end

wire rd_take = s_axi_arvalid && s_axi_arready;
wire istat_clr = rd_take && (ra == `PTC_ISTAT);

always @(posedge aclk)
begin
    if (!aresetn)
    begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid <= 1'b0;
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= `PTC_RESP_OK;
        istat_q <= {4*`PTC_NT{1'b0}};
        irq <= 1'b0;
    end
    else
    begin
        if (rd_take)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_d;
            s_axi_rresp <= rok_d ? `PTC_RESP_OK : `PTC_RESP_ERR;
        end
        if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
        // A flag event in the clearing cycle survives, so no completion is missed.
        istat_q <= (istat_clr ? {4*`PTC_NT{1'b0}} : istat_q) | ev;
        irq <= |(istat_q & imask_q);
    end
end

endmodule // ptc_top

/* hdl/ptc_defs.vh */
// Purpose: Constants for the position teach controller.
// Assumes: Two tasks of two axes each, 32-bit AXI4-Lite registers.
// Notes: Byte addresses; every register is one aligned word.
`ifndef PTC_DEFS_VH
`define PTC_DEFS_VH
`define PTC_NT 2
`define PTC_NA 2
`define PTC_TASK_MASK 16'hFFE0
`define PTC_TASK_AREA 16'h0000
`define PTC_REQ 4'h0
`define PTC_FLG 4'h4
`define PTC_SWD 4'h8
`define PTC_TAD 4'hC
`define PTC_WIN_MASK 16'hFFF0
`define PTC_WIN_BASE 16'h0040
`define PTC_CFG 16'h0060
`define PTC_ISTAT 16'h0070
`define PTC_IMASK 16'h0074
`define PTC_MEM_BASE 16'h2000
`define PTC_DEPTH 16'h07D0
`define PTC_ABS_MAX 16'h07CF
`define PTC_STEP 16'h0002
`define PTC_RQ_SET 0
`define PTC_RQ_TCH 1
`define PTC_FL_SET 0
`define PTC_FL_DONE 1
`define PTC_FL_ERR 2
`define PTC_FL_OVR 3
`define PTC_WLO_RST 16'h0000
`define PTC_WHI_RST 16'h07CF
`define PTC_RESP_OK 2'h0
`define PTC_RESP_ERR 2'h2
`endif

/* bench/ptc_monitor.sv */
// Purpose: Bus timing checks for the position teach controller.
// Assumes: One clock, synchronous active-low reset.
// Notes: Sees top-level ports only; the bind stands at the foot.
`timescale 1ns/100ps
module ptc_monitor (
    input wire aclk,
    input wire aresetn,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire s_axi_rvalid,
    input wire s_axi_rready
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    AST_W_ANS: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("Write answer late.");
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("Write answer dropped.");
    AST_B_DONE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready && s_axi_wready)
        else $error("Write not closed.");
    AST_B_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("Write taken early.");
    AST_R_ANS: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("Read answer late.");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("Read data moved.");
    AST_R_DONE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
        else $error("Read not closed.");
    AST_R_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("Read taken early.");
    cover property (s_axi_bvalid && s_axi_bready);
    cover property (s_axi_rvalid && s_axi_rready);
    cover property (s_axi_rvalid && !s_axi_rready);
endmodule // ptc_monitor
bind ptc_top ptc_monitor mon (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

/* bench/ptc_host.sv */
// Purpose: Host controller model speaking AXI4-Lite.
// Assumes: Signals change by non-blocking assignment after a rising edge.
// Notes: Waits are open; the bench timeout ends a hang.
`timescale 1ns/100ps
module ptc_host (
    input wire aclk,
    output logic [15:0] s_axi_awaddr = '0,
    output logic s_axi_awvalid = 0,
    input wire s_axi_awready,
    output logic [31:0] s_axi_wdata = '0,
    output logic s_axi_wvalid = 0,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    output logic s_axi_bready = 0,
    output logic [15:0] s_axi_araddr = '0,
    output logic s_axi_arvalid = 0,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0] s_axi_rresp,
    input wire s_axi_rvalid,
    output logic s_axi_rready = 0
);
    // Address and data are offered together and each is released when taken.
    // Ready is raised after a random pause, so the slave must hold its answer.
    task automatic wr(input logic [15:0] a, input logic [31:0] v, output logic [1:0] r);
        logic pa = 1;
        logic pw = 1;
        logic pb = 1;
        int w = $urandom % 5;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        {s_axi_awvalid, s_axi_wvalid} <= 2'h3;
        s_axi_bready <= (w == 0);
        while (pb)
        begin
            @(posedge aclk);
            pa = pa && !s_axi_awready;
            pw = pw && !s_axi_wready;
            s_axi_awvalid <= pa;
            s_axi_wvalid <= pw;
            r = s_axi_bresp;
            pb = !(s_axi_bvalid && s_axi_bready);
            w = w - 1;
            s_axi_bready <= pb && (w <= 0);
        end
    endtask
    task automatic rd(input logic [15:0] a, output logic [31:0] v, output logic [1:0] r);
        logic pa = 1;
        logic pr = 1;
        int w = $urandom % 5;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= (w == 0);
        while (pr)
        begin
            @(posedge aclk);
            pa = pa && !s_axi_arready;
            s_axi_arvalid <= pa;
            v = s_axi_rdata;
            r = s_axi_rresp;
            pr = !(s_axi_rvalid && s_axi_rready);
            w = w - 1;
            s_axi_rready <= pr && (w <= 0);
        end
    endtask
endmodule // ptc_host

/* bench/tb_position_teach_controller.sv */
// Purpose: Self-checking bench for the position teach controller.
// Assumes: Axis inputs are held steady while a capture runs.
// Notes: Seeded random positions and pointers among fixed corner cases.
`timescale 1ns/100ps
`include "ptc_defs.vh"
module tb_position_teach_controller;
    logic aclk = 0;
    logic aresetn = 0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [127:0] pos_target = '0, pos_feedback = '0;
    logic [3:0] origin_ok = 4'hF;
    wire [15:0] s_axi_awaddr, s_axi_araddr;
    wire [31:0] s_axi_wdata, s_axi_rdata;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    wire s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, irq;
    int n_mismatch = 0;
    int checked = 0;
    int cyc = 0;
    logic cfg = 0;
    logic [15:0] ptr [2];
    logic [31:0] d;
    logic [1:0] r;
    ptc_top dut (.*);
    ptc_host host (.*);
    always #50 aclk = ~aclk;
    task chk(input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e)
        begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: got %h, expected %h", $time, s, e);
        end
    endtask
    task complete_run;
        $display("Counts: %0d checked, %0d mismatched.", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    function logic [31:0] exp_pos(input int t, input int a);
        return cfg ? pos_feedback[64*t+32*a+:32] : pos_target[64*t+32*a+:32];
    endfunction
    task wreg(input int a, input int v);
        host.wr(16'(a), v, r);
        chk(32'(r), `PTC_RESP_OK);
    endtask
    // Polls the flags word; a hang here is counted rather than left to the timeout.
    task waitf(input int t, input logic z);
        int i;
        for (i = 0; i < 40; i++)
        begin
            host.rd(16'(16 * t + 4), d, r);
            if (z ? d[3:0] === 4'h0 : d[3:0] !== 4'h0)
                break;
        end
        if (i == 40)
            chk(32'h1, 32'h0);
    endtask
    task teach(input int t, input logic ld, input int p, input logic [3:0] ef);
        for (int k = 0; k < 4; k++)
        begin
            pos_target[32*k+:32] <= $urandom;
            pos_feedback[32*k+:32] <= $urandom;
        end
        if (ld)
        begin
            wreg(16 * t + 8, p);
            wreg(16 * t, 1);
            waitf(t, 0);
            chk(d, 1);
            host.rd(16'(16 * t + 12), d, r);
            chk(d, p);
            wreg(16 * t, 0);
            waitf(t, 1);
            ptr[t] = 16'(p);
        end
        wreg(16 * t, 2);
        waitf(t, 0);
        chk(d, ef);
        wreg(16 * t, 0);
        waitf(t, 1);
        if (ef == 4'h2)
        begin
            host.rd(16'(`PTC_MEM_BASE + 4 * ptr[t]), d, r);
            chk(d, exp_pos(t, 0));
            host.rd(16'(`PTC_MEM_BASE + 4 * ptr[t] + 4), d, r);
            chk(d, exp_pos(t, 1));
            ptr[t] += 2;
        end
        host.rd(16'(16 * t + 12), d, r);
        chk(d, ptr[t]);
    endtask
    always @(posedge aclk)
    begin
        cyc++;
        if (cyc == 30000)
        begin
            n_mismatch++;
            complete_run;
        end
    end
    initial
    begin
        void'($urandom(46));
        repeat (3) @(posedge aclk);
        aresetn <= 1;
        host.rd(16'h000C, d, r);
        chk(d, 0);
        host.rd(16'h001C, d, r);
        chk(d, 0);
        host.rd(16'h0044, d, r);
        chk(d, `PTC_WHI_RST);
        host.rd(16'h0100, d, r);
        chk(32'(r), `PTC_RESP_ERR);
        host.wr(16'h0100, 32'h0000_0001, r);
        chk(32'(r), `PTC_RESP_ERR);
        $display("Test reset and map done.");
        teach(0, 1, $urandom % 100, 4'h2);
        host.rd(`PTC_ISTAT, d, r);
        wreg(`PTC_IMASK, 2);
        cfg = 1;
        wreg(`PTC_CFG, 1);
        teach(0, 0, 0, 4'h2);
        chk(32'(irq), 1);
        host.rd(`PTC_ISTAT, d, r);
        chk(d, 2);
        repeat (3) @(posedge aclk);
        chk(32'(irq), 0);
        $display("Test capture and interrupt done.");
        origin_ok <= 4'h7;
        teach(1, 1, 500, 4'h4);
        chk(32'(irq), 0);
        origin_ok <= 4'hF;
        teach(1, 1, 2000, 4'h4);
        host.rd(16'h000C, d, r);
        chk(d, ptr[0]);
        $display("Test teach errors done.");
        wreg(16'h0040, 150);
        wreg(16'h0044, 180);
        teach(0, 1, 149, 4'h8);
        teach(0, 1, 181, 4'h8);
        teach(0, 1, 180, 4'h8);
        teach(0, 1, 179, 4'h2);
        repeat (3) teach(0, 1, 150 + $urandom % 29, 4'h2);
        $display("Test window done.");
        complete_run;
    end
endmodule // tb_position_teach_controller
